// File: ustf_txn_status_ctrl.v
// transaction status queue, engine control and interrupt flags behind an AXI4-Lite slave
//
// How it works
// - status register reads head of four-entry queue
// - each finished descriptor pushes entry behind pending ones
// - clearing token-done flag pops the status queue
// - queued entry left keeps token-done flag raised
// - bits 7 to 4 carry endpoint number
// - bit 2 shows even or odd bank
// - direction bit zero for OUT, one for IN
// - SETUP token sets hold bit, stops transfers
// - software clears hold bit, processing then resumes
// - wakeup bit high drives resume signaling on bus
// - bank clear zeroes bank bits of endpoints 5, 6
// - control bit 0 enables engine, not transceiver
// - setting enable clears banks, reinitialises engine
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`include "ustf_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module ustf_txn_status_ctrl #(
    parameter ADDR_W = `USTF_ADDR_W,
    parameter DEPTH = `USTF_FIFO_DEPTH
) (
    input wire sys_clk,                 // module clock, 125 MHz
    input wire rst_n,                   // synchronous reset, active low
    input wire clk_en,                  // freezes all state while low
    input wire [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire s_axi_awvalid,           // write address valid
    output reg s_axi_awready,           // write address ready
    input wire [31:0] s_axi_wdata,      // write data
    input wire [3:0] s_axi_wstrb,       // write byte enables
    input wire s_axi_wvalid,            // write data valid
    output reg s_axi_wready,            // write data ready
    output reg [1:0] s_axi_bresp,       // write response
    output reg s_axi_bvalid,            // write response valid
    input wire s_axi_bready,            // write response ready
    input wire [ADDR_W-1:0] s_axi_araddr, // read address
    input wire s_axi_arvalid,           // read address valid
    output reg s_axi_arready,           // read address ready
    output reg [31:0] s_axi_rdata,      // read data
    output reg [1:0] s_axi_rresp,       // read response
    output reg s_axi_rvalid,            // read data valid
    input wire s_axi_rready,            // read data ready
    input wire txn_done,                // engine finished with a descriptor
    input wire [3:0] txn_endpoint,      // endpoint of that transaction
    input wire txn_dir_in,              // 1 for IN, 0 for OUT
    input wire txn_bank_odd,            // descriptor came from odd bank
    input wire setup_token,             // SETUP token received
    output reg txn_ready,               // engine may complete a transaction
    output reg token_hold,              // token processing held after SETUP
    output reg remote_wakeup_drive,     // drive resume signaling on the bus
    output reg engine_enable,           // serial interface engine enabled
    output reg engine_reinit,           // one-cycle reinitialise of engine logic
    output reg [1:0] bank_select,       // next bank of endpoints 6 and 5
    output reg irq                      // level interrupt
);

localparam CNT_W = 3;
localparam [CNT_W-1:0] FULL = DEPTH[CNT_W-1:0];
localparam [CNT_W-1:0] ONE = 1;
localparam [CNT_W-1:0] ZERO = 0;

////////////////////////////////////////////////////////////////////////////////
// declarations

reg aw_held;
reg [ADDR_W-1:0] aw_addr;
reg w_held;
reg [7:0] w_byte;
reg w_lane0;
reg setup_flag;
reg token_done_flag;
reg [`USTF_INT_W-1:0] int_enable;
wire [7:0] head;
wire [CNT_W-1:0] count;
wire [7:0] entry;
wire aw_take;
wire w_take;
wire b_take;
wire ar_take;
wire r_take;
wire do_write;
wire wr_lane;
wire wr_control;
wire wr_clear;
wire wr_enable;
wire push;
wire pop;
wire enable_rise;
wire bank_clear;
wire flush;
reg next_aw_held;
reg next_w_held;
reg next_bvalid;
reg next_rvalid;
reg next_token_hold;
reg next_engine_enable;
reg [CNT_W-1:0] next_count;
wire [`USTF_INT_W-1:0] flags;
wire [7:0] control_view;

////////////////////////////////////////////////////////////////////////////////
// address decode

function mapped;
    input [ADDR_W-1:0] a;
    begin
        mapped = (a == `USTF_OFS_RESULT) || (a == `USTF_OFS_CONTROL) ||
                 (a == `USTF_OFS_FLAGS) || (a == `USTF_OFS_CLEAR) ||
                 (a == `USTF_OFS_ENABLE);
    end
endfunction

assign aw_take = s_axi_awvalid && s_axi_awready;
assign w_take = s_axi_wvalid && s_axi_wready;
assign b_take = s_axi_bvalid && s_axi_bready;
assign ar_take = s_axi_arvalid && s_axi_arready;
assign r_take = s_axi_rvalid && s_axi_rready;
// address and data may arrive in either order; the write happens once both are held
assign do_write = aw_held && w_held && !s_axi_bvalid;
// registers live in the low byte lane only
assign wr_lane = do_write && w_lane0;
assign wr_control = wr_lane && (aw_addr == `USTF_OFS_CONTROL);
assign wr_clear = wr_lane && (aw_addr == `USTF_OFS_CLEAR);
assign wr_enable = wr_lane && (aw_addr == `USTF_OFS_ENABLE);

////////////////////////////////////////////////////////////////////////////////
// engine side: queue, stall and bank bits

assign entry = {txn_endpoint, txn_dir_in, txn_bank_odd, 2'h0};
// txn_ready already accounts for fill level, so a push never meets a full queue
assign push = txn_done && txn_ready;
assign pop = wr_clear && w_byte[`USTF_INT_TOKEN_DONE] && token_done_flag;
assign enable_rise = wr_control && w_byte[`USTF_CTL_EN] && !engine_enable;
assign bank_clear = (wr_control && w_byte[`USTF_CTL_BANKCLR]) || enable_rise;
// re-enabling drops stale status along with the rest of the engine state
assign flush = enable_rise;

ustf_status_fifo #(
    .WIDTH(`USTF_FIFO_WIDTH),
    .DEPTH(DEPTH),
    .PTR_W(2),
    .CNT_W(CNT_W)
) u_fifo (
    .clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .flush(flush),
    .push(push),
    .push_data(entry),
    .pop(pop),
    .head(head),
    .count(count)
);

always @*
begin
    next_count = count;
    if (flush)
    begin
        next_count = ZERO;
    end
    else if (push && !pop)
    begin
        next_count = count + ONE;
    end
    else if (pop && !push)
    begin
        next_count = count - ONE;
    end
end

always @*
begin
    next_token_hold = token_hold;
    if (wr_control)
    begin
        next_token_hold = w_byte[`USTF_CTL_HOLD];
    end
    if (setup_token)
    begin
        next_token_hold = 1'b1;
    end
    next_engine_enable = wr_control ? w_byte[`USTF_CTL_EN] : engine_enable;
end

always @(posedge sys_clk)
begin
    if (!rst_n)
    begin
        token_hold <= 1'b0;
        remote_wakeup_drive <= 1'b0;
        engine_enable <= 1'b0;
        engine_reinit <= 1'b0;
        bank_select <= 2'h0;
        txn_ready <= 1'b0;
        token_done_flag <= 1'b0;
        setup_flag <= 1'b0;
    end
    else if (clk_en)
    begin
        token_hold <= next_token_hold;
        engine_enable <= next_engine_enable;
        engine_reinit <= enable_rise;
        if (wr_control)
        begin
            remote_wakeup_drive <= w_byte[`USTF_CTL_WAKE];
        end
        if (bank_clear)
        begin
            bank_select <= 2'h0;
        end
        else if (push && txn_endpoint == `USTF_EP_BANKED_A)
        begin
            bank_select[0] <= ~bank_select[0];
        end
        else if (push && txn_endpoint == `USTF_EP_BANKED_B)
        begin
            bank_select[1] <= ~bank_select[1];
        end
        // stalls while held, disabled or full so no status can be dropped
        txn_ready <= next_engine_enable && !next_token_hold && (next_count != FULL);
        // flag tracks occupancy: a pop that leaves entries keeps it raised
        token_done_flag <= (next_count != ZERO);
        // a new SETUP in the clearing cycle keeps the flag set
        setup_flag <= setup_token ||
                      (setup_flag && !(wr_clear && w_byte[`USTF_INT_SETUP]));
    end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt

assign flags = {setup_flag, token_done_flag};

always @(posedge sys_clk)
begin
    if (!rst_n)
    begin
        int_enable <= `USTF_INT_RESET;
        irq <= 1'b0;
    end
    else if (clk_en)
    begin
        if (wr_enable)
        begin
            int_enable <= w_byte[`USTF_INT_W-1:0];
        end
        irq <= |(flags & int_enable);
    end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite write channel

always @*
begin
    next_aw_held = aw_take ? 1'b1 : (do_write ? 1'b0 : aw_held);
    next_w_held = w_take ? 1'b1 : (do_write ? 1'b0 : w_held);
    next_bvalid = do_write ? 1'b1 : (b_take ? 1'b0 : s_axi_bvalid);
    next_rvalid = ar_take ? 1'b1 : (r_take ? 1'b0 : s_axi_rvalid);
end

always @(posedge sys_clk)
begin
    if (!rst_n)
    begin
        aw_held <= 1'b0;
        aw_addr <= {ADDR_W{1'b0}};
        w_held <= 1'b0;
        w_byte <= 8'h00;
        w_lane0 <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `USTF_RESP_OKAY;
    end
    else if (clk_en)
    begin
        aw_held <= next_aw_held;
        w_held <= next_w_held;
        s_axi_bvalid <= next_bvalid;
        // one write in flight: both readies stay low until the response is taken
        s_axi_awready <= !next_aw_held && !next_bvalid;
        s_axi_wready <= !next_w_held && !next_bvalid;
        if (aw_take)
        begin
            aw_addr <= s_axi_awaddr;
        end
        if (w_take)
        begin
            w_byte <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
        end
        if (do_write)
        begin
            s_axi_bresp <= mapped(aw_addr) ? `USTF_RESP_OKAY : `USTF_RESP_SLVERR;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite read channel

// bank-clear bit always reads zero; it acts only on the write
assign control_view = {2'h0, token_hold, 2'h0, remote_wakeup_drive, 1'b0, engine_enable};

always @(posedge sys_clk)
begin
    if (!rst_n)
    begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `USTF_RESP_OKAY;
    end
    else if (clk_en)
    begin
        s_axi_rvalid <= next_rvalid;
        s_axi_arready <= !next_rvalid;
        if (ar_take)
        begin
            s_axi_rresp <= mapped(s_axi_araddr) ? `USTF_RESP_OKAY : `USTF_RESP_SLVERR;
            case (s_axi_araddr)
                `USTF_OFS_RESULT:
                    // an empty queue reads as zero, meaningless without the flag
                    s_axi_rdata <= {24'h00_0000, token_done_flag ? head : 8'h00};
                `USTF_OFS_CONTROL:
                    s_axi_rdata <= {24'h00_0000, control_view};
                `USTF_OFS_FLAGS:
                    s_axi_rdata <= {30'h0000_0000, flags};
                `USTF_OFS_ENABLE:
                    s_axi_rdata <= {30'h0000_0000, int_enable};
                default:
                    s_axi_rdata <= 32'h0000_0000;
            endcase
        end
    end
end

endmodule
`default_nettype wire

// File: ustf_defines.vh
// register map, field positions, reset values and bus codes of the transaction status block
`ifndef USTF_DEFINES_VH
`define USTF_DEFINES_VH

`define USTF_ADDR_W 8
`define USTF_OFS_RESULT 8'h00
`define USTF_OFS_CONTROL 8'h04
`define USTF_OFS_FLAGS 8'h08
`define USTF_OFS_CLEAR 8'h0c
`define USTF_OFS_ENABLE 8'h10

`define USTF_RES_EP_HI 7
`define USTF_RES_EP_LO 4
`define USTF_RES_DIR 3
`define USTF_RES_BANK 2

`define USTF_CTL_HOLD 5
`define USTF_CTL_WAKE 2
`define USTF_CTL_BANKCLR 1
`define USTF_CTL_EN 0
`define USTF_CTL_RESET 8'h00

`define USTF_INT_TOKEN_DONE 0
`define USTF_INT_SETUP 1
`define USTF_INT_W 2
`define USTF_INT_RESET 2'h0

`define USTF_FIFO_DEPTH 4
`define USTF_FIFO_WIDTH 8
`define USTF_EP_BANKED_A 4'h5
`define USTF_EP_BANKED_B 4'h6

`define USTF_RESP_OKAY 2'h0
`define USTF_RESP_SLVERR 2'h2

`endif

// File: ustf_status_fifo.v
// small circular queue holding completed-transaction status entries
`timescale 1ns/1ps
`default_nettype none
module ustf_status_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter PTR_W = 2,
    parameter CNT_W = 3
) (
    input wire clk,                     // module clock
    input wire rst_n,                   // synchronous reset, active low
    input wire clk_en,                  // freezes all state while low
    input wire flush,                   // drop every entry
    input wire push,                    // store push_data
    input wire [WIDTH-1:0] push_data,   // entry to store
    input wire pop,                     // discard the head entry
    output wire [WIDTH-1:0] head,       // oldest entry
    output reg [CNT_W-1:0] count        // entries held
);

localparam [PTR_W-1:0] LAST = DEPTH[PTR_W-1:0] - {{(PTR_W-1){1'b0}}, 1'b1};
localparam [CNT_W-1:0] FULL = DEPTH[CNT_W-1:0];
localparam [CNT_W-1:0] ONE = 1;

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [PTR_W-1:0] wr_ptr;
reg [PTR_W-1:0] rd_ptr;
wire do_push;
wire do_pop;

function [PTR_W-1:0] bump;
    input [PTR_W-1:0] p;
    begin
        bump = (p == LAST) ? {PTR_W{1'b0}} : p + {{(PTR_W-1){1'b0}}, 1'b1};
    end
endfunction

// a push into a full queue or a pop from an empty one is ignored
assign do_push = push && (count != FULL);
assign do_pop = pop && (count != {CNT_W{1'b0}});
assign head = mem[rd_ptr];

always @(posedge clk)
begin
    if (clk_en && do_push && !flush)
    begin
        mem[wr_ptr] <= push_data;
    end
end

always @(posedge clk)
begin
    if (!rst_n)
    begin
        wr_ptr <= {PTR_W{1'b0}};
        rd_ptr <= {PTR_W{1'b0}};
        count <= {CNT_W{1'b0}};
    end
    else if (clk_en)
    begin
        if (flush)
        begin
            wr_ptr <= {PTR_W{1'b0}};
            rd_ptr <= {PTR_W{1'b0}};
            count <= {CNT_W{1'b0}};
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr <= bump(wr_ptr);
            end
            if (do_pop)
            begin
                rd_ptr <= bump(rd_ptr);
            end
            if (do_push && !do_pop)
            begin
                count <= count + ONE;
            end
            else if (do_pop && !do_push)
            begin
                count <= count - ONE;
            end
        end
    end
end

endmodule
`default_nettype wire

// File: ustf_checker.sv
// concurrent checks on the ports of the transaction status block
`timescale 1ns/1ps
`default_nettype none
module ustf_checker #(
    parameter ADDR_W = 8
) (
    input wire logic sys_clk, // module clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic clk_en, // state freeze while low
    input wire logic s_axi_arvalid, // read address valid
    input wire logic s_axi_arready, // read address ready
    input wire logic [31:0] s_axi_rdata, // read data
    input wire logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic [1:0] s_axi_bresp, // write response
    input wire logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic txn_done, // completion offered
    input wire logic txn_ready, // completion allowed
    input wire logic setup_token, // setup seen
    input wire logic token_hold, // hold after setup
    input wire logic engine_enable, // engine enabled
    input wire logic engine_reinit, // reinit pulse
    input wire logic irq // level interrupt
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    AST_HOLD_SET: assert property (setup_token && clk_en |=> token_hold)
        else $error("hold not set after setup");
    // one cycle of slack; the ready flop takes next_token_hold, so it never trails the hold bit
    AST_HOLD_STALL: assert property (token_hold && $past(token_hold) |-> !txn_ready)
        else $error("ready while held");
    AST_DIS_STALL: assert property (!engine_enable && $past(!engine_enable) |-> !txn_ready)
        else $error("ready while disabled");
    AST_REINIT_PULSE: assert property (engine_reinit && clk_en |=> !engine_reinit)
        else $error("reinit longer than one cycle");
    AST_REINIT_EN: assert property (engine_reinit |-> engine_enable)
        else $error("reinit without enable");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
        else $error("no read answer");
    AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    COV_PUSH: cover property (txn_done && txn_ready);
    COV_SETUP: cover property (setup_token ##1 token_hold);
    COV_IRQ: cover property ($rose(irq));
endmodule
bind ustf_txn_status_ctrl ustf_checker #(.ADDR_W(ADDR_W)) u_chk (.sys_clk(sys_clk),
    .rst_n(rst_n), .clk_en(clk_en), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .txn_done(txn_done), .txn_ready(txn_ready),
    .setup_token(setup_token), .token_hold(token_hold), .engine_enable(engine_enable),
    .engine_reinit(engine_reinit), .irq(irq));
`default_nettype wire

// File: ustf_engine_model.sv
// engine-side model offering finished transactions to the status block
`timescale 1ns/1ps
`default_nettype none
module ustf_engine_model (
    input wire logic sys_clk, // module clock
    input wire logic txn_ready, // device accepts a completion
    output logic txn_done, // completion offered
    output logic [3:0] txn_endpoint, // endpoint of the completion
    output logic txn_dir_in, // 1 for IN
    output logic txn_bank_odd // odd bank
);
    logic [5:0] q[$];
    logic [5:0] f;
    assign {txn_endpoint, txn_dir_in, txn_bank_odd} = f;
    initial
    begin
        txn_done = 1'b0;
        f = 6'h00;
    end
    task put(input logic [5:0] v);
        q.push_back(v);
    endtask
    // a refused completion is offered again, never lost
    always @(posedge sys_clk)
    begin
        if (txn_done && txn_ready)
        begin
            txn_done <= 1'b0;
            f <= ~f;
        end
        else if (!txn_done && q.size() != 0)
        begin
            txn_done <= 1'b1;
            f <= q.pop_front();
        end
    end
endmodule
`default_nettype wire

// File: tb.sv
// self-checking bench for the transaction status block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0, rst_n = 1'b0, setup = 1'b0, ce = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire logic awready, wready, bvalid, arready, rvalid, done, dir, odd;
    wire logic rdy, hold, wake, en, reinit, irq;
    wire logic [1:0] bresp, rresp, bank;
    wire logic [31:0] rdata;
    wire logic [3:0] ep;
    int failures = 0, total_checks = 0, cyc = 0;
    logic [5:0] tv [0:4] = '{6'h14, 6'h1b, 6'h02, 6'h0d, 6'h12};
    initial forever #4 sys_clk = ~sys_clk;
    ustf_txn_status_ctrl u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .txn_done(done), .txn_endpoint(ep), .txn_dir_in(dir), .txn_bank_odd(odd),
        .setup_token(setup), .txn_ready(rdy), .token_hold(hold), .remote_wakeup_drive(wake),
        .engine_enable(en), .engine_reinit(reinit), .bank_select(bank), .irq(irq));
    ustf_engine_model u_eng (.sys_clk(sys_clk), .txn_ready(rdy), .txn_done(done),
        .txn_endpoint(ep), .txn_dir_in(dir), .txn_bank_odd(odd));
    ////////////////////////////////////////////////////////////////////////////////
    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // bvalid can only follow both takes, so it ends the loop
        forever
        begin
            @(posedge sys_clk);
            if (bvalid === 1'b1)
                break;
            if (aw && awready === 1'b1)
            begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1)
            begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b0;
        chk(bresp, er);
        // let an edge pass so a following call never re-raises bready in this step
        @(posedge sys_clk);
    endtask
    task axr(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge sys_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge sys_clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, {24'h0, ed});
        chk(rresp, er);
        @(posedge sys_clk);
    endtask
    task drain;
        while (u_eng.q.size() != 0 || done !== 1'b0)
            @(posedge sys_clk);
        repeat (2) @(posedge sys_clk);
    endtask
    function automatic logic [7:0] res(input logic [5:0] v);
        return {v, 2'b00};
    endfunction
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        axr(8'h04, 8'h00, 2'h0);
        axr(8'h10, 8'h00, 2'h0);
        axr(8'h00, 8'h00, 2'h0);
        axr(8'h14, 8'h00, 2'h2);
        axw(8'h14, 8'h01, 2'h2);
        axw(8'h04, 8'h01, 2'h0);
        axw(8'h10, 8'h03, 2'h0);
        axr(8'h10, 8'h03, 2'h0);
        for (int i = 0; i < 5; i++)
            u_eng.put(tv[i]);
        repeat (30) @(posedge sys_clk);
        chk(rdy, 1'b0);
        chk(done, 1'b1);
        chk(irq, 1'b1);
        chk(bank, 2'b11);
        axw(8'h10, 8'h02, 2'h0);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b0);
        axw(8'h10, 8'h03, 2'h0);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b1);
        for (int i = 0; i < 5; i++)
        begin
            axr(8'h08, 8'h01, 2'h0);
            axr(8'h00, res(tv[i]), 2'h0);
            axw(8'h0c, 8'h01, 2'h0);
        end
        axr(8'h08, 8'h00, 2'h0);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b0);
        axw(8'h04, 8'h03, 2'h0);
        chk(bank, 2'b00);
        axr(8'h04, 8'h01, 2'h0);
        u_eng.put(6'h14);
        drain();
        chk(bank, 2'b01);
        axw(8'h04, 8'h00, 2'h0);
        chk(en, 1'b0);
        chk(rdy, 1'b0);
        axw(8'h04, 8'h01, 2'h0);
        chk(bank, 2'b00);
        axr(8'h08, 8'h00, 2'h0);
        @(posedge sys_clk);
        setup <= 1'b1;
        @(posedge sys_clk);
        setup <= 1'b0;
        u_eng.put(6'h0a);
        repeat (6) @(posedge sys_clk);
        chk(hold, 1'b1);
        chk(done, 1'b1);
        axr(8'h04, 8'h21, 2'h0);
        axr(8'h08, 8'h02, 2'h0);
        axw(8'h0c, 8'h02, 2'h0);
        axw(8'h04, 8'h01, 2'h0);
        drain();
        chk(hold, 1'b0);
        axr(8'h00, res(6'h0a), 2'h0);
        axw(8'h0c, 8'h01, 2'h0);
        axw(8'h04, 8'h05, 2'h0);
        chk(wake, 1'b1);
        axw(8'h04, 8'h01, 2'h0);
        chk(wake, 1'b0);
        // a setup pulse while frozen must leave no trace
        ce <= 1'b0;
        setup <= 1'b1;
        @(posedge sys_clk);
        setup <= 1'b0;
        ce <= 1'b1;
        @(posedge sys_clk);
        chk(hold, 1'b0);
        axr(8'h08, 8'h00, 2'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
